/* common/ttc_map.svh */
// register selects, field positions, reset values and timing counts
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH
`define TTC_SEL_CTRL13 3'h0
`define TTC_SEL_CTRL2 3'h1
`define TTC_BIT_INT_RST 0
`define TTC_BIT_CLK_SRC 1
`define TTC_BIT_DUAL 2
`define TTC_BIT_MEAS 3
`define TTC_BIT_INIT_SRC 4
`define TTC_BIT_SENSE 5
`define TTC_BIT_MASK 6
`define TTC_BIT_OUT_EN 7
`define TTC_BIT_COMPOSITE 7
`define TTC_LATCH_RESET 16'hFFFF
`define TTC_CTRL1_RESET 8'h01
`define TTC_SYNC_STAGES 3
`define TTC_PRESCALE_BITS 3
`endif

/* common/ttc_pkg.sv */
// shared types of the triple timer
package ttc_pkg;
    typedef logic [15:0] ttc_word_t;
    typedef logic [7:0] ttc_byte_t;
    typedef enum logic [1:0] {
        TTC_CONT = 2'b00,
        TTC_ONESHOT = 2'b01,
        TTC_FREQ = 2'b10,
        TTC_PULSE = 2'b11
    } ttc_mode_t;
endpackage

/* common/ttc_chan_if.sv */
// bundle between the main block and one timer channel
`timescale 1ns/100ps
interface ttc_chan_if;
    logic [7:0] ctrl;
    logic [15:0] latch;
    logic init;
    logic tick;
    logic gate_fall;
    logic gate_lvl;
    logic hold;
    logic [15:0] count;
    logic timeout;
    logic out_lvl;
    modport top (output ctrl, latch, init, tick, gate_fall, gate_lvl, hold,
                 input count, timeout, out_lvl);
    modport chan (input ctrl, latch, init, tick, gate_fall, gate_lvl, hold,
                  output count, timeout, out_lvl);
endinterface

/* rtl/ttc_sync.sv */
// three-stage input synchroniser with agreement and fall detection
`timescale 1ns/100ps
module ttc_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // raw input and synchronised results
    input wire logic raw_in,
    output logic lvl,
    output logic fall
);
    logic [2:0] sh_reg; // synchroniser stages
    // ------------------------------------------------------------
    // sampling chain
    // ------------------------------------------------------------
    // stage 0 feeds only stage 1; level changes once stages 1 and 2 agree
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sh_reg <= 3'h0;
            lvl <= 1'b0;
        end else if (clk_en) begin
            sh_reg <= {sh_reg[1:0], raw_in};
            if (sh_reg[1] == sh_reg[2]) begin
                lvl <= sh_reg[2];
            end
        end
    end
    // falling edge of the agreed level, fourth sample pulse
    always_comb begin
        fall = lvl & (sh_reg[1] == sh_reg[2]) & ~sh_reg[2];
    end
endmodule // ttc_sync

/* rtl/ttc_chan.sv */
// one 16-bit down counter with output waveform logic
`timescale 1ns/100ps
`include "ttc_map.svh"
module ttc_chan (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // channel bundle
    ttc_chan_if.chan ch
);
    import ttc_pkg::*;
    logic [15:0] cnt_reg; // down counter
    logic out_reg; // raw waveform before enable
    logic dual;
    logic zero;
    logic lsb_zero;
    logic run;
    ttc_mode_t mode;
    always_comb begin
        dual = ch.ctrl[`TTC_BIT_DUAL];
        mode = ttc_mode_t'({ch.ctrl[`TTC_BIT_MEAS], ch.ctrl[`TTC_BIT_SENSE]});
        zero = (cnt_reg == 16'h0000);
        lsb_zero = (cnt_reg[7:0] == 8'h00);
        // continuous needs gate low, single-shot does not
        run = ch.tick & ~ch.hold & ((mode == TTC_ONESHOT) | ~ch.gate_lvl);
        ch.count = cnt_reg;
        ch.timeout = run & zero;
        ch.out_lvl = out_reg & ch.ctrl[`TTC_BIT_OUT_EN];
    end
    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= `TTC_LATCH_RESET;
        end else if (clk_en) begin
            if (ch.init) begin
                cnt_reg <= ch.latch;
            end else if (run) begin
                if (zero) begin
                    cnt_reg <= ch.latch;
                end else if (dual && lsb_zero) begin
                    // dual byte: reload low byte, step high byte
                    cnt_reg <= {cnt_reg[15:8] - 8'h01, ch.latch[7:0]};
                end else begin
                    cnt_reg <= cnt_reg - 16'h0001;
                end
            end
        end
    end
    // ------------------------------------------------------------
    // waveform
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= 1'b0;
        end else if (clk_en) begin
            if (ch.hold) begin
                out_reg <= 1'b0;
            end else if (ch.init) begin
                out_reg <= 1'b0;
            end else if (run) begin
                if (!dual) begin
                    // square wave or one pulse
                    if (zero) begin
                        out_reg <= (mode == TTC_ONESHOT) ? 1'b0 : ~out_reg;
                    end else if (mode == TTC_ONESHOT && cnt_reg == ch.latch) begin
                        out_reg <= 1'b1;
                    end
                end else begin
                    // high after the high byte empties, low at time-out
                    if (zero) begin
                        out_reg <= 1'b0;
                    end else if (cnt_reg[15:8] == 8'h00) begin
                        out_reg <= 1'b1;
                    end
                end
            end
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_out_gated: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        !ch.ctrl[`TTC_BIT_OUT_EN] |-> !ch.out_lvl)
        else $error("output high while disabled");
    a_init_loads: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && ch.init |=> cnt_reg == $past(ch.latch))
        else $error("init did not load latch");
    a_zero_reload: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && run && zero && !ch.init |=> cnt_reg == $past(ch.latch))
        else $error("no reload at zero");
    a_freeze_holds: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        !clk_en |=> $stable(cnt_reg) && $stable(out_reg))
        else $error("state moved while frozen");
    c_timeout: cover property (@(posedge sys_clk) ch.timeout);
endmodule // ttc_chan

/* rtl/ttc_top.sv */
// triple 16-bit timer core behind a byte-wide register-select bus
// ------------------------------------------------------------
// What this block does
// - timer reset clears every individual flag
// - counter read clears flag after flagged status read
// - latch write or init clears that timer's flag
// - 16-bit counter and latch; init copies latch
// - shared staging byte fills latch upper half
// - external reset sets every latch to 65535
// - internal reset leaves latches untouched
// - bits 3,5 select continuous or single-shot init
// - measure mode compares gate interval with time-out
// - any reset condition performs counter initialization
// - clock at zero count reloads from latch
// - external clocks synchronised, count on fourth pulse
// - timer 3 optional divide-by-8 ripple prescaler
// - late prescaler edge may wait one cycle
// - gates synchronised like clocks, fourth pulse
// - gate acts on counter regardless of prescaler
// - square, single pulse, or variable-duty output
// - output low while its enable is clear
// - composite flag from masked individual flags
// - internal reset presets, halts, clears outputs
// - count lengths N+1 or (L+1)(M+1)
// ------------------------------------------------------------
`timescale 1ns/100ps
`include "ttc_map.svh"
module ttc_top #(
    parameter int NCH = 3
) (
    // clock, enable and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // external reset pin, active low
    input wire logic ext_reset_n,
    // register bus
    input wire logic [2:0] reg_sel,
    input wire logic bus_sel,
    input wire logic bus_read,
    input wire logic [7:0] bus_wdata,
    output logic [7:0] bus_rdata,
    output logic irq_n,
    // timer pins
    input wire logic ext_count_in_1,
    input wire logic ext_count_in_2,
    input wire logic ext_count_in_3,
    input wire logic gate_in_1,
    input wire logic gate_in_2,
    input wire logic gate_in_3,
    output logic timer_out_1,
    output logic timer_out_2,
    output logic timer_out_3
);
    import ttc_pkg::*;
    ttc_chan_if chif [NCH] ();
    logic [7:0] ctrl_reg [NCH]; // control registers
    ttc_word_t latch_reg [NCH]; // reload latches
    ttc_byte_t latch_high_byte_staging_reg; // shared high byte
    ttc_byte_t lsb_hold_reg; // frozen low byte
    logic [NCH-1:0] flag_reg; // individual flags
    logic [NCH-1:0] armed_reg; // status seen while flag set
    logic [2:0] presc_reg; // timer 3 prescaler
    logic [NCH-1:0] clk_lvl;
    logic [NCH-1:0] clk_fall;
    logic [NCH-1:0] gate_lvl;
    logic [NCH-1:0] gate_fall;
    logic ext_rst_lvl;
    logic int_reset;
    logic any_reset;
    logic [NCH-1:0] wr_latch;
    logic [NCH-1:0] rd_cnt;
    logic [NCH-1:0] init;
    logic [NCH-1:0] timeout;
    logic [NCH-1:0] gate_meas_ok;
    logic [15:0] cnt [NCH];
    logic [NCH-1:0] outs;
    logic composite;
    logic wr;
    logic rd;
    logic [NCH-1:0] raw_clk;
    logic [NCH-1:0] raw_gate;
    logic [NCH-1:0] tick;
    // timer index selected by a latch or counter address
    function automatic int sel_timer(input logic [2:0] s);
        return int'(s[2:1]) - 1;
    endfunction
    always_comb begin
        raw_clk = {ext_count_in_3, ext_count_in_2, ext_count_in_1};
        raw_gate = {gate_in_3, gate_in_2, gate_in_1};
        wr = bus_sel & ~bus_read;
        rd = bus_sel & bus_read;
        int_reset = ctrl_reg[0][`TTC_BIT_INT_RST];
        any_reset = ~ext_rst_lvl | int_reset;
    end
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    ttc_sync u_rst_sync (
        .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .raw_in(ext_reset_n), .lvl(ext_rst_lvl), .fall()
    );
    // prescaler ripples on the raw pin, its msb is then synchronised
    always_ff @(negedge ext_count_in_3 or negedge arst_n) begin
        if (!arst_n) begin
            presc_reg <= 3'h0;
        end else begin
            presc_reg <= presc_reg + 3'h1;
        end
    end
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_in
            logic src;
            // late prescaler edges simply land one sample later
            assign src = (gi == 2 && ctrl_reg[2][0]) ? presc_reg[2]
                                                     : raw_clk[gi];
            ttc_sync u_csync (
                .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
                .raw_in(src), .lvl(clk_lvl[gi]), .fall(clk_fall[gi])
            );
            ttc_sync u_gsync (
                .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
                .raw_in(raw_gate[gi]), .lvl(gate_lvl[gi]),
                .fall(gate_fall[gi])
            );
        end
    endgenerate
    // ------------------------------------------------------------
    // bus writes: control, staging, latches
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl_reg[i] <= 8'h00;
                latch_reg[i] <= `TTC_LATCH_RESET;
            end
            ctrl_reg[0] <= `TTC_CTRL1_RESET;
            latch_high_byte_staging_reg <= 8'h00;
        end else if (clk_en) begin
            if (!ext_rst_lvl) begin
                for (int i = 0; i < NCH; i++) begin
                    ctrl_reg[i] <= 8'h00;
                    latch_reg[i] <= `TTC_LATCH_RESET;
                end
                ctrl_reg[0] <= `TTC_CTRL1_RESET;
            end else if (wr) begin
                // latches written regardless of internal reset
                if (reg_sel == `TTC_SEL_CTRL13) begin
                    if (ctrl_reg[1][0]) ctrl_reg[0] <= bus_wdata;
                    else ctrl_reg[2] <= bus_wdata;
                end else if (reg_sel == `TTC_SEL_CTRL2) begin
                    ctrl_reg[1] <= bus_wdata;
                end else if (!reg_sel[0]) begin
                    latch_high_byte_staging_reg <= bus_wdata;
                end else begin
                    latch_reg[sel_timer(reg_sel)] <=
                        {latch_high_byte_staging_reg, bus_wdata};
                end
            end
        end
    end
    // ------------------------------------------------------------
    // per-timer init, gating and measurement
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            wr_latch[i] = wr & reg_sel[0] & (reg_sel[2:1] != 2'h0) &
                          (sel_timer(reg_sel) == i);
            rd_cnt[i] = rd & ~reg_sel[0] & (reg_sel[2:1] != 2'h0) &
                        (sel_timer(reg_sel) == i);
            // reset, gate fall, or latch write when init source is 0
            init[i] = any_reset | gate_fall[i] |
                      (wr_latch[i] & ~ctrl_reg[i][`TTC_BIT_INIT_SRC]);
            tick[i] = ctrl_reg[i][`TTC_BIT_CLK_SRC] ? clk_fall[i] : 1'b1;
        end
    end
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            always_comb begin
                chif[gi].ctrl = ctrl_reg[gi];
                // a latch write that inits hands the new word straight on
                chif[gi].latch = (wr_latch[gi] && ext_rst_lvl) ?
                    {latch_high_byte_staging_reg, bus_wdata} : latch_reg[gi];
                chif[gi].init = init[gi];
                chif[gi].tick = tick[gi];
                chif[gi].gate_fall = gate_fall[gi];
                chif[gi].gate_lvl = gate_lvl[gi];
                chif[gi].hold = any_reset;
                cnt[gi] = chif[gi].count;
                outs[gi] = chif[gi].out_lvl;
                timeout[gi] = chif[gi].timeout;
            end
            ttc_chan u_chan (
                .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
                .ch(chif[gi])
            );
        end
    endgenerate
    // measurement: short interval flags at gate fall, long interval flags at time-out
    logic [NCH-1:0] to_seen_reg; // time-out seen since last init (reset, gate fall or latch write)
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            to_seen_reg <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NCH; i++) begin
                if (init[i]) to_seen_reg[i] <= 1'b0;
                else if (timeout[i]) to_seen_reg[i] <= 1'b1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (!ctrl_reg[i][`TTC_BIT_MEAS]) begin
                gate_meas_ok[i] = timeout[i];
            end else if (!ctrl_reg[i][`TTC_BIT_SENSE]) begin
                // shorter than time-out
                gate_meas_ok[i] = gate_fall[i] & ~to_seen_reg[i];
            end else begin
                // longer than time-out
                gate_meas_ok[i] = timeout[i] & ~to_seen_reg[i];
            end
        end
    end
    // ------------------------------------------------------------
    // interrupt flags, reset wins over set, set wins over other clears
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_reg <= '0;
            armed_reg <= '0;
        end else if (clk_en) begin
            for (int i = 0; i < NCH; i++) begin
                if (any_reset) begin
                    flag_reg[i] <= 1'b0;
                    armed_reg[i] <= 1'b0;
                end else if (gate_meas_ok[i]) begin
                    flag_reg[i] <= 1'b1;
                end else if (wr_latch[i] || init[i]) begin
                    flag_reg[i] <= 1'b0;
                    armed_reg[i] <= 1'b0;
                end else if (rd_cnt[i] && armed_reg[i]) begin
                    flag_reg[i] <= 1'b0;
                    armed_reg[i] <= 1'b0;
                end else if (rd && reg_sel == `TTC_SEL_CTRL2 && flag_reg[i]) begin
                    armed_reg[i] <= 1'b1;
                end
            end
        end
    end
    always_comb begin
        composite = 1'b0;
        for (int i = 0; i < NCH; i++) begin
            composite = composite |
                        (flag_reg[i] & ctrl_reg[i][`TTC_BIT_MASK]);
        end
        irq_n = ~composite;
        {timer_out_3, timer_out_2, timer_out_1} = outs;
    end
    // ------------------------------------------------------------
    // read path with coherent low byte
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            lsb_hold_reg <= 8'h00;
            bus_rdata <= 8'h00;
        end else if (clk_en) begin
            if (rd) begin
                if (reg_sel == `TTC_SEL_CTRL2) begin
                    bus_rdata <= {composite, 4'h0, flag_reg};
                end else if (reg_sel == `TTC_SEL_CTRL13) begin
                    bus_rdata <= 8'h00;
                end else if (!reg_sel[0]) begin
                    bus_rdata <= cnt[sel_timer(reg_sel)][15:8];
                    lsb_hold_reg <= cnt[sel_timer(reg_sel)][7:0];
                end else begin
                    bus_rdata <= lsb_hold_reg;
                end
            end
        end
    end
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_reset_clears: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && any_reset |=> flag_reg == '0)
        else $error("flags survive reset");
    a_ext_latch_max: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && !ext_rst_lvl |=> latch_reg[1] == `TTC_LATCH_RESET)
        else $error("latch not at maximum");
    a_int_keeps_latch: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && ext_rst_lvl && int_reset && !wr |=> $stable(latch_reg[0]))
        else $error("internal reset changed latch");
    a_latch_pair: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && ext_rst_lvl && wr_latch[0] |=>
        latch_reg[0] == {$past(latch_high_byte_staging_reg),
                         $past(bus_wdata)})
        else $error("latch pair wrong");
    a_irq_composite: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        flag_reg[0] && ctrl_reg[0][`TTC_BIT_MASK] |-> !irq_n)
        else $error("composite flag missing");
    a_read_clear: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && rd_cnt[0] && !armed_reg[0] && flag_reg[0] && !init[0]
        |=> flag_reg[0])
        else $error("unarmed read cleared flag");
    a_status_then_counter_read_clear: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && rd_cnt[0] && armed_reg[0] && !gate_meas_ok[0]
        |=> !flag_reg[0])
        else $error("armed read kept flag");
    a_wr_clears: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && wr_latch[1] && !gate_meas_ok[1] |=> !flag_reg[1])
        else $error("latch write kept flag");
    a_write_inits: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && ext_rst_lvl && wr_latch[2] &&
        !ctrl_reg[2][`TTC_BIT_INIT_SRC] |=> cnt[2] == latch_reg[2])
        else $error("latch write did not init counter");
    a_gate_inits: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && gate_fall[1] && !wr_latch[1]
        |=> cnt[1] == $past(latch_reg[1]))
        else $error("gate fall did not init counter");
    a_reset_inits: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && any_reset && !wr_latch[2]
        |=> cnt[2] == $past(latch_reg[2]))
        else $error("reset did not init counter");
    a_hold_outs: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && int_reset |=> !timer_out_1 && !timer_out_2 && !timer_out_3)
        else $error("output high under internal reset");
    a_lsb_hold: assert property (@(posedge sys_clk)
        disable iff (!arst_n)
        clk_en && rd_cnt[0] |=> lsb_hold_reg == $past(cnt[0][7:0]))
        else $error("low byte not held");
    c_flag_set: cover property (@(posedge sys_clk) $rose(flag_reg[0]));
    c_irq: cover property (@(posedge sys_clk) $fell(irq_n));
    c_status_then_counter_read: cover property (@(posedge sys_clk) rd_cnt[0] && armed_reg[0]);
endmodule // ttc_top

/* sim/ttc_bus_model.sv */
// bus master model for the timer register-select bus
`timescale 1ns/100ps
module ttc_bus_model (
    // clock
    input wire logic sys_clk,
    // register-select bus
    output logic [2:0] reg_sel,
    output logic bus_sel,
    output logic bus_read,
    output logic [7:0] bus_wdata,
    input wire logic [7:0] bus_rdata
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // idle bus from time zero
    initial begin
        reg_sel = 3'h0;
        bus_sel = 1'b0;
        bus_read = 1'b1;
        bus_wdata = 8'h00;
    end
    // one access: drive after an edge, hold through the taking edge
    task automatic xfer(input logic [2:0] sel, input logic rd,
                        input logic [7:0] wd, output logic [7:0] q);
        @(posedge sys_clk);
        #1;
        reg_sel = sel;
        bus_read = rd;
        bus_wdata = wd;
        bus_sel = 1'b1;
        @(posedge sys_clk);
        #1;
        q = bus_rdata;
        bus_sel = 1'b0;
        // released data must not keep showing the last byte
        bus_wdata = ~wd;
    endtask
    // single byte write
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        logic [7:0] q;
        xfer(sel, 1'b0, d, q);
    endtask
    // single byte read
    task automatic rd(input logic [2:0] sel, output logic [7:0] q);
        xfer(sel, 1'b1, bus_wdata, q);
    endtask
    // staging byte first, then the low byte to the latch
    task automatic load(input logic [1:0] idx, input logic [15:0] v);
        wr({idx, 1'b0}, v[15:8]);
        wr({idx, 1'b1}, v[7:0]);
    endtask
    // counter high byte first so the low byte is frozen with it
    task automatic read16(input logic [1:0] idx, output logic [15:0] v);
        rd({idx, 1'b0}, v[15:8]);
        rd({idx, 1'b1}, v[7:0]);
    endtask
endmodule // ttc_bus_model

/* sim/tb_top.sv */
// self-checking bench for the triple timer core
`timescale 1ns/100ps
`include "ttc_map.svh"
module tb_top;
    // ----------------------------------------
    // clock, reset and pins
    // ----------------------------------------
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic ext_reset_n = 1'b1;
    logic [2:0] reg_sel;
    logic bus_sel;
    logic bus_read;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic irq_n;
    logic [3:1] cnt_in = 3'h0;
    logic [3:1] gate_in = 3'h0;
    logic [3:1] t_out;
    logic [7:0] s;
    logic [15:0] w;
    logic [31:0] rb;
    logic [2:0] slot = 3'h0;
    logic [31:0] seed = 32'h0000_0028;
    int fails = 0;
    int total_checks = 0;
    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;
    // design and bus master
    ttc_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en),
        .ext_reset_n(ext_reset_n), .reg_sel(reg_sel), .bus_sel(bus_sel),
        .bus_read(bus_read), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .irq_n(irq_n), .ext_count_in_1(cnt_in[1]),
        .ext_count_in_2(cnt_in[2]), .ext_count_in_3(cnt_in[3]),
        .gate_in_1(gate_in[1]), .gate_in_2(gate_in[2]),
        .gate_in_3(gate_in[3]), .timer_out_1(t_out[1]),
        .timer_out_2(t_out[2]), .timer_out_3(t_out[3]));
    ttc_bus_model u_bus (.sys_clk(sys_clk), .reg_sel(reg_sel),
        .bus_sel(bus_sel), .bus_read(bus_read), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // xorshift source, fixed start
    function automatic logic [31:0] next_rand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish();
        if (fails == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a wait that ran out
    task automatic lose();
        fails++;
        tally_and_finish();
    endtask
    // bounded wait for the composite interrupt
    task automatic wait_irq();
        for (int n = 0; irq_n !== 1'b0; n++) begin
            if (n > 300) lose();
            @(posedge sys_clk);
            #1;
        end
    endtask
    // slow random levels on channel 2 and 3 pins, held eight cycles
    always @(posedge sys_clk) begin
        #1;
        slot = slot + 3'h1;
        if (slot == 3'h0) begin
            rb = next_rand();
            {gate_in[3:2], cnt_in[3:2]} = rb[3:0];
        end
    end
    // overall run limit
    initial begin
        repeat (20000) @(posedge sys_clk);
        lose();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] v;
        repeat (12) @(posedge sys_clk);
        #1;
        arst_n = 1'b1;
        // held counters show the reset latch, then each new latch
        u_bus.read16(2'd1, w);
        check(w, `TTC_LATCH_RESET);
        for (int i = 1; i <= 3; i++) begin
            w = 16'(next_rand());
            v = (i == 1) ? 16'h0040 : w;
            u_bus.load(2'(i), v);
            u_bus.read16(2'(i), w);
            check(w, v);
        end
        // run timer 1 with its interrupt unmasked, output off
        u_bus.wr(3'h1, 8'h01);
        u_bus.wr(3'h0, 8'h40);
        wait_irq();
        check(16'(t_out[1]), 16'h0000);
        // counter read alone keeps the flag, after status it clears
        u_bus.read16(2'd1, w);
        u_bus.rd(3'h1, s);
        check(16'({s[7], s[0]}), 16'h0003);
        u_bus.read16(2'd1, w);
        u_bus.rd(3'h1, s);
        check(16'({s[7], s[0]}), 16'h0000);
        // latch write clears a standing flag
        wait_irq();
        u_bus.load(2'd1, 16'h0040);
        u_bus.rd(3'h1, s);
        check(16'(s[0]), 16'h0000);
        // masked flag stays off the composite; a short freeze on the way
        u_bus.wr(3'h0, 8'h00);
        clk_en = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        clk_en = 1'b1;
        repeat (80) @(posedge sys_clk);
        u_bus.rd(3'h1, s);
        check(16'({irq_n, s[7], s[0]}), 16'h0005);
        // output follows the wave, then drops with its enable
        u_bus.wr(3'h0, 8'h80);
        for (int n = 0; t_out[1] !== 1'b1; n++) begin
            if (n > 300) lose();
            @(posedge sys_clk);
            #1;
        end
        u_bus.wr(3'h0, 8'h00);
        @(posedge sys_clk);
        #1;
        check(16'(t_out[1]), 16'h0000);
        // internal reset keeps latches, presets counters, clears flags
        u_bus.wr(3'h0, 8'h01);
        u_bus.read16(2'd1, w);
        check(w, 16'h0040);
        u_bus.rd(3'h1, s);
        check(16'(s), 16'h0000);
        // pin reset while a flag stands
        u_bus.wr(3'h0, 8'h40);
        wait_irq();
        ext_reset_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        ext_reset_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        u_bus.rd(3'h1, s);
        check(16'({irq_n, s}), 16'h0100);
        u_bus.read16(2'd3, w);
        check(w, `TTC_LATCH_RESET);
        tally_and_finish();
    end
endmodule // tb_top
